// File: rtl/rtcirq_pkg.sv
package rtcirq_pkg;
  // register offsets
  localparam logic [16:0] ADDR_ALARM_DATE = 17'h1fff5;
  localparam logic [16:0] ADDR_IRQ_CTRL = 17'h1fff6;
  localparam logic [16:0] ADDR_WDOG_CTRL = 17'h1fff7;
  localparam logic [16:0] ADDR_FLAGS = 17'h1fff0;
  // irq_source_control fields
  localparam int IRQ_WDOG_EN_BIT = 7;
  localparam int IRQ_ALARM_EN_BIT = 6;
  localparam int IRQ_PWR_EN_BIT = 5;
  localparam int IRQ_HL_BIT = 3;
  localparam int IRQ_PL_BIT = 2;
  localparam logic [7:0] IRQ_WR_MASK = 8'hec;
  // watchdog_control fields
  localparam int WD_STROBE_BIT = 7;
  localparam int WD_GATE_BIT = 6;
  // flag register fields
  localparam int FLG_WD_BIT = 2;
  localparam int FLG_AL_BIT = 1;
  localparam int FLG_PWR_BIT = 0;
  // reset values
  localparam logic [7:0] RST_ALARM_DATE = 8'h00;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h00;
  localparam logic [5:0] RST_WD_TIMEOUT = 6'h00;
  // timing: watchdog tick is 1/32 s
  localparam int CLK_HZ = 40000000;
  localparam int TICK_HZ = 32;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  // pulse mode width on the interrupt pin
  localparam int PULSE_NS = 200;
  localparam int PULSE_CYCLES = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;

  typedef struct packed {
    logic [16:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rtcirq_bus_s;

  typedef struct packed {
    logic wd_expired;
    logic alarm_match;
    logic power_loss;
  } rtcirq_flags_s;
endpackage : rtcirq_pkg

// File: rtl/rtcirq_wdog.sv
`timescale 1ns/100ps
module rtcirq_wdog #(
  parameter int TICK_CYC = rtcirq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] timeout,
  input wire logic restart,
  output logic expire
);
  if (TICK_CYC < 2) begin : g_tick_chk
    $error("tick count too small");
  end

  typedef struct packed {
    logic [31:0] div;
    logic [5:0] ticks;
  } rtcirq_wd_s;

  rtcirq_wd_s s_q, s_d;
  logic tick;

  always_comb begin
    s_d = s_q;
    expire = 1'b0;
    tick = (s_q.div == 32'(TICK_CYC - 1));
    s_d.div = tick ? 32'h0 : s_q.div + 32'h1;
    if (restart || timeout == 6'h00) begin
      s_d.ticks = 6'h00;
      s_d.div = 32'h0;
    end else if (tick) begin
      if (s_q.ticks + 6'h01 >= timeout) begin
        expire = 1'b1;
        s_d.ticks = 6'h00;
      end else begin
        s_d.ticks = s_q.ticks + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : rtcirq_wdog

// File: rtl/rtcirq_top.sv
`timescale 1ns/100ps
module rtcirq_top #(
  parameter int TICK_CYC = rtcirq_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [16:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic alarm_match_in,
  input wire logic power_fail_in,
  output logic irq_o,
  output logic irq_oe
);
  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (TICK_CYC < 2) begin : g_tick_chk
    $error("tick count too small");
  end

  if (rtcirq_pkg::PULSE_CYCLES < 1 || rtcirq_pkg::PULSE_CYCLES > 255) begin : g_pulse_chk
    $error("pulse width does not fit its counter");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // address decode, shared by the write strobes and the flag read strobe
  function automatic logic addr_hit(input logic [16:0] addr, input logic [16:0] target);
    addr_hit = (addr == target);
  endfunction : addr_hit

  // rising edge of a synchronised level
  function automatic logic rise(input logic now, input logic last);
    rise = now && !last;
  endfunction : rise

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] am_sync;
    logic [1:0] pwr_sync;
    logic am_last;
    logic pwr_last;
    logic [7:0] alarm_date;
    logic [7:0] ctrl;
    logic [5:0] wd_timeout;
    logic wd_gate;
    rtcirq_pkg::rtcirq_flags_s flags;
    logic irq_level;
    logic [7:0] pulse_cnt;
    logic [7:0] rdata;
  } rtcirq_top_s;

  rtcirq_top_s s_q;
  rtcirq_top_s s_d;
  rtcirq_pkg::rtcirq_bus_s bus;
  logic wd_expire;
  logic wd_restart;
  logic am_evt;
  logic pwr_evt;
  logic wd_irq;
  logic am_irq;
  logic pwr_irq;
  logic any_irq;
  logic flag_rd;
  logic date_wr;
  logic ctrl_wr;
  logic wdog_wr;
  logic pulse_mode;
  logic high_mode;
  logic irq_act;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign date_wr = bus.wr && addr_hit(bus.addr, rtcirq_pkg::ADDR_ALARM_DATE);
  assign ctrl_wr = bus.wr && addr_hit(bus.addr, rtcirq_pkg::ADDR_IRQ_CTRL);
  assign wdog_wr = bus.wr && addr_hit(bus.addr, rtcirq_pkg::ADDR_WDOG_CTRL);
  assign flag_rd = bus.rd && addr_hit(bus.addr, rtcirq_pkg::ADDR_FLAGS);
  // strobe restarts the count and is never stored
  assign wd_restart = wdog_wr && bus.wdata[rtcirq_pkg::WD_STROBE_BIT];
  assign pulse_mode = s_q.ctrl[rtcirq_pkg::IRQ_PL_BIT];
  assign high_mode = s_q.ctrl[rtcirq_pkg::IRQ_HL_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog counter

  rtcirq_wdog #(.TICK_CYC(TICK_CYC)) u_wdog (
    .clk(clk),
    .rst_n(rst_n),
    .timeout(s_q.wd_timeout),
    .restart(wd_restart),
    .expire(wd_expire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    // two-flop synchronisers, then edge detect
    s_d.am_sync = {s_q.am_sync[0], alarm_match_in};
    s_d.pwr_sync = {s_q.pwr_sync[0], power_fail_in};
    s_d.am_last = s_q.am_sync[1];
    s_d.pwr_last = s_q.pwr_sync[1];
    am_evt = rise(s_q.am_sync[1], s_q.am_last);
    pwr_evt = rise(s_q.pwr_sync[1], s_q.pwr_last);
    // source gating onto the shared pin
    wd_irq = wd_expire && s_q.ctrl[rtcirq_pkg::IRQ_WDOG_EN_BIT];
    am_irq = am_evt && s_q.ctrl[rtcirq_pkg::IRQ_ALARM_EN_BIT];
    pwr_irq = pwr_evt && s_q.ctrl[rtcirq_pkg::IRQ_PWR_EN_BIT];
    any_irq = wd_irq || am_irq || pwr_irq;
    // flags clear on read; a same-cycle event wins
    if (flag_rd) begin
      s_d.flags = '0;
      if (!pulse_mode) begin
        s_d.irq_level = 1'b0;
      end
    end
    if (wd_expire) begin
      s_d.flags.wd_expired = 1'b1;
    end
    if (am_evt) begin
      s_d.flags.alarm_match = 1'b1;
    end
    if (pwr_evt) begin
      s_d.flags.power_loss = 1'b1;
    end
    // pin activity: a counted pulse or a level held until flags are read
    if (s_q.pulse_cnt != 8'h00) begin
      s_d.pulse_cnt = s_q.pulse_cnt - 8'h01;
    end
    if (any_irq) begin
      if (pulse_mode) begin
        s_d.pulse_cnt = 8'(rtcirq_pkg::PULSE_CYCLES);
      end else begin
        s_d.irq_level = 1'b1;
      end
    end
    // register writes
    if (date_wr) begin
      s_d.alarm_date = bus.wdata;
    end
    if (ctrl_wr) begin
      s_d.ctrl = bus.wdata & rtcirq_pkg::IRQ_WR_MASK;
    end
    if (wdog_wr) begin
      // gate set: timeout kept, strobe still acts
      if (!s_q.wd_gate) begin
        s_d.wd_timeout = bus.wdata[5:0];
      end
      s_d.wd_gate = bus.wdata[rtcirq_pkg::WD_GATE_BIT];
    end
    // read data stand for one cycle only
    s_d.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        rtcirq_pkg::ADDR_ALARM_DATE: begin
          s_d.rdata = s_q.alarm_date;
        end
        rtcirq_pkg::ADDR_IRQ_CTRL: begin
          s_d.rdata = s_q.ctrl;
        end
        rtcirq_pkg::ADDR_WDOG_CTRL: begin
          s_d.rdata = {1'b0, s_q.wd_gate, s_q.wd_timeout};
        end
        rtcirq_pkg::ADDR_FLAGS: begin
          s_d.rdata = {5'h00, s_q.flags};
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.alarm_date <= rtcirq_pkg::RST_ALARM_DATE;
      s_q.ctrl <= rtcirq_pkg::RST_IRQ_CTRL;
      s_q.wd_timeout <= rtcirq_pkg::RST_WD_TIMEOUT;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive

  assign irq_act = s_q.irq_level || (s_q.pulse_cnt != 8'h00);
  assign reg_rdata = s_q.rdata;

  always_comb begin
    if (high_mode) begin
      irq_o = irq_act;
      irq_oe = 1'b1;
    end else begin
      irq_o = 1'b0;
      irq_oe = irq_act;
    end
  end
endmodule : rtcirq_top

// File: verif/rtcirq_host.sv
`timescale 1ns/100ps
module rtcirq_host (
  input wire logic irq_o,
  input wire logic irq_oe,
  output logic pin
);
  // released line is pulled up
  assign pin = irq_oe ? irq_o : 1'b1;
endmodule : rtcirq_host

// File: verif/rtcirq_chk.sv
`timescale 1ns/100ps
module rtcirq_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [16:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic alarm_match_in,
  input wire logic power_fail_in,
  input wire logic irq_o,
  input wire logic irq_oe
);
  logic [7:0] c_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) c_q <= 8'h00;
    else if (reg_wr && reg_addr == rtcirq_pkg::ADDR_IRQ_CTRL) c_q <= reg_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_arm;
    $rose(alarm_match_in) && c_q[6] && c_q[3];
  endsequence
  a_pin_drive: assert property (irq_o |-> irq_oe)
    else $error("pin level without drive");
  a_od_low: assert property (!c_q[3] && !$past(c_q[3]) |-> !irq_o)
    else $error("open drain pin driven high");
  a_pol_high: assert property (c_q[3] && $past(c_q[3]) |-> irq_oe)
    else $error("high polarity pin not driven");
  a_quiet_pin: assert property (c_q[7:5] == 3'h0 && $past(c_q[7:5]) == 3'h0
    |-> !irq_o && irq_oe == c_q[3]) else $error("pin active with sources off");
  a_ctrl_rsv: assert property (reg_rd && reg_addr == rtcirq_pkg::ADDR_IRQ_CTRL
    |=> reg_rdata == (c_q & rtcirq_pkg::IRQ_WR_MASK)) else $error("control readback");
  a_strobe_rd: assert property (reg_rd && reg_addr == rtcirq_pkg::ADDR_WDOG_CTRL
    |=> !reg_rdata[7]) else $error("strobe bit reads one");
  a_al_pin: assert property (s_arm |-> ##[1:4] irq_o)
    else $error("alarm did not raise pin");
  a_pwr_pin: assert property ($rose(power_fail_in) && c_q[5] && !c_q[3]
    |-> ##[1:4] irq_oe) else $error("power fail did not pull pin");
endmodule : rtcirq_chk
bind rtcirq_top rtcirq_chk chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .alarm_match_in(alarm_match_in), .power_fail_in(power_fail_in), .irq_o(irq_o),
  .irq_oe(irq_oe));

// File: verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [16:0] a = 17'h00000;
  logic [7:0] d = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic al = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] q;
  logic io, ioe, pin;
  int error_cnt = 0;
  int total_checks = 0;
  rtcirq_top #(.TICK_CYC(10)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(a), .reg_wdata(d),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(q), .alarm_match_in(al), .power_fail_in(pwr),
    .irq_o(io), .irq_oe(ioe));
  rtcirq_host host_u (.irq_o(io), .irq_oe(ioe), .pin(pin));
  initial forever #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr8(input logic [16:0] ad, input logic [7:0] v);
    @(posedge clk);
    a <= ad;
    d <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr8
  task automatic rc(input logic [16:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, q)
  endtask : rc
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////
  task automatic t_ctrl;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'hff);
    rc(rtcirq_pkg::ADDR_IRQ_CTRL, 8'hec);
    wr8(rtcirq_pkg::ADDR_ALARM_DATE, 8'h5a);
    rc(rtcirq_pkg::ADDR_ALARM_DATE, 8'h5a);
    rc(17'h00000, 8'h00);
  endtask : t_ctrl
  task automatic t_alarm;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h48);
    al <= 1'b1;
    cyc(5);
    `CHK("pin", 1'b1, pin)
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h02);
    `CHK("pin", 1'b0, pin)
    al <= 1'b0;
  endtask : t_alarm
  task automatic t_pwr;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h00);
    pwr <= 1'b1;
    cyc(5);
    `CHK("pin", 1'b1, pin)
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h01);
    pwr <= 1'b0;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h20);
    pwr <= 1'b1;
    cyc(5);
    `CHK("pin", 1'b0, pin)
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h01);
    pwr <= 1'b0;
  endtask : t_pwr
  task automatic t_wd;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h00);
    wr8(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h01);
    cyc(40);
    `CHK("pin", 1'b1, pin)
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h04);
    rc(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h01);
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h80);
    for (int i = 0; i < 50 && pin !== 1'b0; i++) cyc(1);
    `CHK("pin", 1'b0, pin)
    wr8(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h00);
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h04);
    cyc(40);
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h00);
  endtask : t_wd
  task automatic t_strobe;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h00);
    wr8(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h43);
    rc(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h43);
    wr8(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h05);
    rc(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h03);
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h00);
    repeat (6) begin
      wr8(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h83);
      cyc(10);
    end
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h00);
    rc(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h03);
    cyc(40);
    wr8(rtcirq_pkg::ADDR_WDOG_CTRL, 8'h00);
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h04);
  endtask : t_strobe
  task automatic t_pulse;
    int n;
    n = 0;
    wr8(rtcirq_pkg::ADDR_IRQ_CTRL, 8'h4c);
    al <= 1'b1;
    cyc(4);
    `CHK("pin", 1'b1, pin)
    for (int i = 0; i < 20 && pin === 1'b1; i++) begin
      cyc(1);
      n++;
    end
    `CHK("pulse", rtcirq_pkg::PULSE_CYCLES, n + 1)
    rc(rtcirq_pkg::ADDR_FLAGS, 8'h02);
    al <= 1'b0;
  endtask : t_pulse
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_ctrl();
    t_alarm();
    t_pwr();
    t_wd();
    t_strobe();
    t_pulse();
    test_done();
  end
endmodule : tb_top
